/* bench/host_model.sv */
// Host model: submits commands to the registrar on its plain command ports.
// Assumes one clock; the registrar answers each taken request with one pulse.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Command request
  output logic cmd_valid,
  output logic cmd_is_resv,
  output logic [1:0] cmd_op,
  output logic [1:0] cmd_ns,
  output logic [1:0] cmd_host,
  output logic cmd_has_rights,
  output logic [2:0] cmd_action,
  output logic cmd_ignore_key,
  output logic [63:0] cmd_current_key,
  output logic [63:0] cmd_new_key,
  // Completion
  input wire logic cpl_valid,
  input wire logic [1:0] cpl_status
);
  // Idle request lines at time zero
  initial begin
    cmd_valid = 1'b0;
    {cmd_is_resv, cmd_op, cmd_ns, cmd_host, cmd_has_rights} = '0;
    {cmd_action, cmd_ignore_key, cmd_current_key, cmd_new_key} = '0;
  end

  // One request; fields held to the taking edge, then action and keys scrambled
  task automatic issue(input logic rv, input logic [1:0] op, input logic [1:0] ns,
      input logic [1:0] hs, input logic rt, input logic [2:0] act, input logic ign,
      input logic [63:0] ck, input logic [63:0] nk, output logic got, output logic [1:0] st);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_is_resv <= rv;
    cmd_op <= op;
    cmd_ns <= ns;
    cmd_host <= hs;
    cmd_has_rights <= rt;
    cmd_action <= act;
    cmd_ignore_key <= ign;
    cmd_current_key <= ck;
    cmd_new_key <= nk;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_action <= ~act;
    cmd_current_key <= ~ck;
    cmd_new_key <= ~nk;
    // Completion due at the very next edge, no slack
    @(posedge clk);
    #1;
    got = cpl_valid;
    st = cpl_status;
  endtask
endmodule
`default_nettype wire

/* bench/namespace_reservation_registrar_tb.sv */
// Testbench for the reservation registrar: support, keys, notes, persist flag.
// Assumes the host model drives the command ports; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module namespace_reservation_registrar_tb;
  logic clk;
  logic arst_n;
  logic ctrl_resv_support;
  logic [3:0] ns_resv_support;
  logic [3:0] ns_attached;
  logic [11:0] note_mask;
  logic [3:0] persist_set_en;
  logic persist_set_value;
  logic [3:0] ns_reserved;
  logic note_valid;
  logic [1:0] note_kind;
  logic [1:0] note_ns;
  logic cmd_valid, cmd_is_resv, cmd_has_rights, cmd_ignore_key;
  logic [1:0] cmd_op, cmd_ns, cmd_host;
  logic [2:0] cmd_action;
  logic [63:0] cmd_current_key, cmd_new_key;
  logic cpl_valid, busy, log_create;
  logic [1:0] cpl_status, log_kind, log_ns;
  logic [7:0] ocs;
  logic [31:0] resv_cap;
  logic [3:0] persist;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  // ----------------------------------------
  // Design, host and clock
  // ----------------------------------------
  resv_registrar #(.num_ns(4), .num_hosts(4), .key_w(64)) DUT (
    .clk(clk), .arst_n(arst_n), .ctrl_resv_support(ctrl_resv_support),
    .ns_resv_support(ns_resv_support), .ns_attached(ns_attached), .note_mask(note_mask),
    .persist_set_en(persist_set_en), .persist_set_value(persist_set_value),
    .cmd_valid(cmd_valid),
    .cmd_is_resv(cmd_is_resv), .cmd_op(cmd_op), .cmd_ns(cmd_ns), .cmd_host(cmd_host),
    .cmd_has_rights(cmd_has_rights), .cmd_action(cmd_action),
    .cmd_ignore_key(cmd_ignore_key), .cmd_current_key(cmd_current_key),
    .cmd_new_key(cmd_new_key), .ns_reserved(ns_reserved), .note_valid(note_valid),
    .note_kind(note_kind), .note_ns(note_ns), .cpl_valid(cpl_valid),
    .cpl_status(cpl_status), .busy(busy), .optional_command_support_field(ocs),
    .reservation_capability_field(resv_cap), .power_loss_persist_state(persist),
    .log_create(log_create), .log_kind(log_kind), .log_ns(log_ns));

  host_model host (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_is_resv(cmd_is_resv), .cmd_op(cmd_op),
    .cmd_ns(cmd_ns), .cmd_host(cmd_host), .cmd_has_rights(cmd_has_rights),
    .cmd_action(cmd_action), .cmd_ignore_key(cmd_ignore_key),
    .cmd_current_key(cmd_current_key), .cmd_new_key(cmd_new_key),
    .cpl_valid(cpl_valid), .cpl_status(cpl_status));

  // Clock of 100 ns period
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("Timeout after %0d cycles", cycles);
      final_report();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One command and its completion status
  task automatic cmd(input logic rv, input logic [1:0] op, input logic [1:0] ns,
      input logic [1:0] hs, input logic rt, input logic [2:0] act, input logic ign,
      input logic [63:0] ck, input logic [63:0] nk, input logic [1:0] exp);
    logic got;
    logic [1:0] st;
    host.issue(rv, op, ns, hs, rt, act, ign, ck, nk, got, st);
    check("cpl_valid", {63'h0, got}, 64'h1);
    check("cpl_status", {62'h0, st}, {62'h0, exp});
    check("busy", {63'h0, busy}, 64'h1);
  endtask

  // Register-type command with rights
  task automatic rg(input logic [1:0] ns, input logic [1:0] hs, input logic [2:0] act,
      input logic ign, input logic [63:0] ck, input logic [63:0] nk, input logic [1:0] exp);
    cmd(1'b1, resv_pkg::op_register, ns, hs, 1'b1, act, ign, ck, nk, exp);
  endtask

  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_identify();
    ctrl_resv_support <= 1'b1;
    ns_resv_support <= 4'h5;
    repeat (2) @(posedge clk);
    #1;
    check("ocs", {56'h0, ocs}, 64'h1 << resv_pkg::opt_cmd_resv_bit);
    check("resv_cap", {32'h0, resv_cap}, 64'h003f003f);
    @(posedge clk);
    ctrl_resv_support <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("ocs off", {56'h0, ocs}, 64'h0);
    $display("Test identify done");
  endtask

  task automatic t_support();
    for (int op = 0; op < 4; op++) begin
      cmd(1'b1, 2'(op), 2'h0, 2'h0, 1'b1, 3'h0, 1'b0, 64'h0, 64'h1,
        resv_pkg::st_invalid_opcode);
    end
    ctrl_resv_support <= 1'b1;
    cmd(1'b1, resv_pkg::op_register, 2'h1, 2'h0, 1'b1, 3'h0, 1'b0, 64'h0, 64'h1,
      resv_pkg::st_invalid_opcode);
    cmd(1'b0, 2'h0, 2'h1, 2'h0, 1'b1, 3'h0, 1'b0, 64'h0, 64'h1, resv_pkg::st_success);
    cmd(1'b1, resv_pkg::op_acquire, 2'h0, 2'h0, 1'b1, 3'h0, 1'b0, 64'h0, 64'h1,
      resv_pkg::st_success);
    $display("Test support done");
  endtask

  task automatic t_keys();
    ns_resv_support <= 4'hf;
    rg(2'h0, 2'h0, resv_pkg::act_register, 1'b0, 64'h0, 64'ha1, resv_pkg::st_success);
    rg(2'h0, 2'h0, resv_pkg::act_register, 1'b0, 64'h0, 64'ha1, resv_pkg::st_success);
    rg(2'h0, 2'h0, resv_pkg::act_register, 1'b0, 64'h0, 64'hb2, resv_pkg::st_conflict);
    rg(2'h0, 2'h1, resv_pkg::act_register, 1'b0, 64'h0, 64'ha1, resv_pkg::st_success);
    rg(2'h0, 2'h2, resv_pkg::act_unregister, 1'b0, 64'ha1, 64'h0, resv_pkg::st_conflict);
    rg(2'h0, 2'h1, resv_pkg::act_unregister, 1'b0, 64'hb2, 64'h0, resv_pkg::st_conflict);
    rg(2'h0, 2'h1, resv_pkg::act_unregister, 1'b0, 64'ha1, 64'h0, resv_pkg::st_success);
    rg(2'h0, 2'h1, resv_pkg::act_register, 1'b0, 64'h0, 64'hb2, resv_pkg::st_success);
    rg(2'h0, 2'h0, resv_pkg::act_replace, 1'b0, 64'hb2, 64'hc3, resv_pkg::st_conflict);
    rg(2'h0, 2'h0, resv_pkg::act_replace, 1'b0, 64'ha1, 64'hc3, resv_pkg::st_success);
    rg(2'h0, 2'h0, resv_pkg::act_register, 1'b0, 64'h0, 64'ha1, resv_pkg::st_conflict);
    rg(2'h0, 2'h0, resv_pkg::act_register, 1'b0, 64'h0, 64'hc3, resv_pkg::st_success);
    rg(2'h0, 2'h3, resv_pkg::act_replace, 1'b1, 64'h0, 64'hd4, resv_pkg::st_success);
    rg(2'h0, 2'h3, resv_pkg::act_register, 1'b0, 64'h0, 64'hd4, resv_pkg::st_success);
    ns_reserved <= 4'h1;
    cmd(1'b1, resv_pkg::op_register, 2'h0, 2'h0, 1'b0, 3'h0, 1'b0, 64'h0, 64'hc3,
      resv_pkg::st_conflict);
    rg(2'h0, 2'h0, resv_pkg::act_replace, 1'b0, 64'hc3, 64'ha1, resv_pkg::st_success);
    rg(2'h0, 2'h2, resv_pkg::act_unregister, 1'b1, 64'h0, 64'h0, resv_pkg::st_conflict);
    rg(2'h0, 2'h0, resv_pkg::act_unregister, 1'b1, 64'h0, 64'h0, resv_pkg::st_success);
    rg(2'h0, 2'h0, resv_pkg::act_replace, 1'b0, 64'ha1, 64'hb2, resv_pkg::st_conflict);
    ns_reserved <= 4'h0;
    for (int h = 0; h < 4; h++) begin
      rg(2'h3, 2'(h), resv_pkg::act_register, 1'b0, 64'h0, 64'he5, resv_pkg::st_success);
    end
    $display("Test keys done");
  endtask

  // Each kind on each namespace, unmasked then masked, then unattached
  task automatic t_notes();
    for (int k = 1; k < 4; k++) begin
      for (int n = 0; n < 5; n++) begin
        for (int m = 0; m < 2; m++) begin
          @(posedge clk);
          ns_attached <= (n == 4) ? 4'h0 : 4'hf;
          note_mask <= m ? (12'h1 << ((n % 4) * 3 + k - 1)) : 12'h0;
          note_valid <= 1'b1;
          note_kind <= 2'(k);
          note_ns <= 2'(n % 4);
          @(posedge clk);
          note_valid <= 1'b0;
          #1;
          check("log_create", {63'h0, log_create}, {63'h0, (m == 0 && n < 4)});
          if (m == 0 && n < 4) begin
            check("log_kind", {62'h0, log_kind}, 64'(k));
            check("log_ns", {62'h0, log_ns}, 64'(n));
          end
        end
      end
    end
    $display("Test notes done");
  endtask

  task automatic t_persist();
    ns_resv_support <= 4'h5;
    @(posedge clk);
    persist_set_value <= 1'b1;
    persist_set_en <= 4'hf;
    @(posedge clk);
    persist_set_en <= 4'h1;
    persist_set_value <= 1'b0;
    @(posedge clk);
    persist_set_en <= 4'h0;
    @(posedge clk);
    #1;
    check("persist", {60'h0, persist}, 64'h4);
    $display("Test persist done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    {ctrl_resv_support, ns_resv_support, ns_reserved, persist_set_en, persist_set_value} = '0;
    {note_valid, note_kind, note_ns, note_mask} = '0;
    ns_attached = 4'hf;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_identify();
    t_support();
    t_keys();
    t_notes();
    t_persist();
    final_report();
  end
endmodule
`default_nettype wire

/* verilog/resv_key_table.sv */
// Key table: one registrant flag and key per namespace and host slot.
// Assumes writes come from the registrar only, one entry per cycle.
`timescale 1ns/1ps
`default_nettype none
module resv_key_table #(
  parameter int num_ns = 4,
  parameter int num_hosts = 4,
  parameter int key_w = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Lookup
  input wire logic [$clog2(num_ns)-1:0] rd_ns,
  input wire logic [$clog2(num_hosts)-1:0] rd_host,
  output logic rd_valid,
  output logic [key_w-1:0] rd_key,
  // Update
  input wire logic wr_en,
  input wire logic [$clog2(num_ns)-1:0] wr_ns,
  input wire logic [$clog2(num_hosts)-1:0] wr_host,
  input wire logic wr_valid,
  input wire logic [key_w-1:0] wr_key
);
  localparam int entries = num_ns * num_hosts;
  localparam int idx_w = $clog2(entries);
  logic [entries-1:0] valid;
  logic [key_w-1:0] key [entries];
  logic [idx_w-1:0] rd_idx;
  logic [idx_w-1:0] wr_idx;

  // Entry index from namespace and host
  assign rd_idx = idx_w'(rd_ns * num_hosts + rd_host);
  assign wr_idx = idx_w'(wr_ns * num_hosts + wr_host);
  assign rd_valid = valid[rd_idx];
  assign rd_key = key[rd_idx];

  // One flag and key per entry, updated together
  genvar g;
  generate
    for (g = 0; g < entries; g++) begin : g_ent
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          valid[g] <= 1'b0;
          key[g] <= '0;
        end else if (wr_en && wr_idx == idx_w'(g)) begin
          valid[g] <= wr_valid;
          key[g] <= wr_key;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* verilog/resv_note_gate.sv */
// Notification gate: filters reservation notifications by kind and namespace mask.
// Assumes one notification per cycle at most.
`timescale 1ns/1ps
`default_nettype none
module resv_note_gate #(
  parameter int num_ns = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Mask, one bit per kind per namespace
  input wire logic [num_ns*resv_pkg::num_note_kinds-1:0] note_mask,
  // Incoming notification
  input wire logic note_valid,
  input wire logic [1:0] note_kind,
  input wire logic [$clog2(num_ns)-1:0] note_ns,
  input wire logic note_attached,
  // Log entry creation
  output logic log_create,
  output logic [1:0] log_kind,
  output logic [$clog2(num_ns)-1:0] log_ns
);
  logic masked;
  logic kind_ok;

  // Mask lookup per namespace and kind
  assign kind_ok = note_kind != 2'h0;
  assign masked = kind_ok &&
    note_mask[note_ns * resv_pkg::num_note_kinds + int'(note_kind) - 1];

  // Log entry pulse for unmasked notifications
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      log_create <= 1'b0;
      log_kind <= 2'h0;
      log_ns <= '0;
    end else begin
      log_create <= note_valid && kind_ok && note_attached && !masked;
      if (note_valid) begin
        log_kind <= note_kind;
        log_ns <= note_ns;
      end
    end
  end

  chk_masked_no_log: assert property (@(posedge clk) disable iff (!arst_n)
    note_valid && masked |=> !log_create) else $error("masked note logged");
  chk_unmasked_logs: assert property (@(posedge clk) disable iff (!arst_n)
    note_valid && kind_ok && note_attached && !masked |=> log_create)
    else $error("unmasked note lost");
endmodule
`default_nettype wire

/* verilog/resv_pkg.sv */
// Constants and types shared by the reservation registrar.
// Assumes a single clock domain and plain-port command interface.
`default_nettype none
package resv_pkg;
  // Register action field encodings
  localparam logic [2:0] act_register = 3'h0;
  localparam logic [2:0] act_unregister = 3'h1;
  localparam logic [2:0] act_replace = 3'h2;
  // Command opcodes seen by the checker
  localparam logic [1:0] op_report = 2'h0;
  localparam logic [1:0] op_register = 2'h1;
  localparam logic [1:0] op_acquire = 2'h2;
  localparam logic [1:0] op_release = 2'h3;
  // Completion status codes
  localparam logic [1:0] st_success = 2'h0;
  localparam logic [1:0] st_invalid_opcode = 2'h1;
  localparam logic [1:0] st_conflict = 2'h2;
  // Identify data fields
  localparam int opt_cmd_resv_bit = 5;
  localparam logic [7:0] resv_cap_value = 8'h3f;
  // Notification kinds
  localparam int num_note_kinds = 3;
  localparam logic [1:0] note_reg_preempted = 2'h1;
  localparam logic [1:0] note_resv_released = 2'h2;
  localparam logic [1:0] note_resv_preempted = 2'h3;
  // Reset values
  localparam logic persist_reset = 1'b0;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_look = 2'b01,
    st_done = 2'b11
  } reg_state_e;
endpackage
`default_nettype wire

/* verilog/resv_registrar.sv */
// Reservation registrar: support checks, key registration, conflict checks.
// Assumes commands arrive on plain ports, one at a time, with host slot resolved.
//
// What this block does
// - Reservation commands abort invalid-opcode unless controller and namespace support them.
// - Controller identify reports support in optional command bit five.
// - Command on reserved namespace without rights aborts with conflict.
// - Capable namespace reports nonzero capability; others report zero.
// - Table holds a key per host slot per namespace; never exhausted.
// - All controllers share one support setting for the subsystem.
// - Supporting controller implements the reservation commands and features; only register acts here, acquire, release and report change nothing.
// - Each capable namespace keeps a power-loss persist state flag.
// - Three notification kinds; unmasked ones on attached namespaces log entries.
// - Masked notifications, per kind and namespace, create no log entry.
// - Registrations keyed by host identifier, shared across its controllers.
// - Register action 000b with new key records the host as registrant.
// - Re-registering with the same key is accepted.
// - Re-registering with a different key aborts with conflict.
// - Identical keys across different hosts are allowed.
// - Replace action 010b carries current and new key.
// - Replace with mismatched current key aborts with conflict.
// - Ignore-existing-key on replace installs new key unconditionally.
// - Replacing a key leaves the reservation untouched.
// - Unregister 001b needs registration and, unless ignore-existing-key is set, a matching key, else conflict.
`timescale 1ns/1ps
`default_nettype none
module resv_registrar #(
  parameter int num_ns = 4,
  parameter int num_hosts = 4,
  parameter int key_w = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Configuration
  input wire logic ctrl_resv_support,
  input wire logic [num_ns-1:0] ns_resv_support,
  input wire logic [num_ns-1:0] ns_attached,
  input wire logic [num_ns*resv_pkg::num_note_kinds-1:0] note_mask,
  input wire logic [num_ns-1:0] persist_set_en,
  input wire logic persist_set_value,
  // Command request
  input wire logic cmd_valid,
  input wire logic cmd_is_resv,
  input wire logic [1:0] cmd_op,
  input wire logic [$clog2(num_ns)-1:0] cmd_ns,
  input wire logic [$clog2(num_hosts)-1:0] cmd_host,
  input wire logic cmd_has_rights,
  input wire logic [2:0] cmd_action,
  input wire logic cmd_ignore_key,
  input wire logic [key_w-1:0] cmd_current_key,
  input wire logic [key_w-1:0] cmd_new_key,
  // Reservation held per namespace
  input wire logic [num_ns-1:0] ns_reserved,
  // Notifications from reservation logic
  input wire logic note_valid,
  input wire logic [1:0] note_kind,
  input wire logic [$clog2(num_ns)-1:0] note_ns,
  // Completion
  output logic cpl_valid,
  output logic [1:0] cpl_status,
  output logic busy,
  // Identify data
  output logic [7:0] optional_command_support_field,
  output logic [num_ns*8-1:0] reservation_capability_field,
  output logic [num_ns-1:0] power_loss_persist_state,
  // Notification log
  output logic log_create,
  output logic [1:0] log_kind,
  output logic [$clog2(num_ns)-1:0] log_ns
);
  resv_pkg::reg_state_e state;
  logic [1:0] op;
  logic [$clog2(num_ns)-1:0] ns;
  logic [$clog2(num_hosts)-1:0] host;
  logic [2:0] action;
  logic ignore_key;
  logic rights;
  logic reserved;
  logic supported;
  logic [key_w-1:0] cur_key;
  logic [key_w-1:0] new_key;
  logic rd_valid;
  logic [key_w-1:0] rd_key;
  logic wr_en;
  logic wr_valid;
  logic [key_w-1:0] wr_key;
  logic [1:0] next_status;

  // Per-host key table, one slot per host and namespace
  resv_key_table #(.num_ns(num_ns), .num_hosts(num_hosts), .key_w(key_w)) u_table (
    .clk(clk),
    .arst_n(arst_n),
    .rd_ns(ns),
    .rd_host(host),
    .rd_valid(rd_valid),
    .rd_key(rd_key),
    .wr_en(wr_en),
    .wr_ns(ns),
    .wr_host(host),
    .wr_valid(wr_valid),
    .wr_key(wr_key)
  );

  // Notification filter
  resv_note_gate #(.num_ns(num_ns)) u_gate (
    .clk(clk),
    .arst_n(arst_n),
    .note_mask(note_mask),
    .note_valid(note_valid),
    .note_kind(note_kind),
    .note_ns(note_ns),
    .note_attached(ns_attached[note_ns]),
    .log_create(log_create),
    .log_kind(log_kind),
    .log_ns(log_ns)
  );

  // --------------------------------------------------------------
  // Command capture
  // --------------------------------------------------------------
  // Latch command fields when idle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op <= resv_pkg::op_report;
      ns <= '0;
      host <= '0;
      action <= resv_pkg::act_register;
      ignore_key <= 1'b0;
      rights <= 1'b0;
      reserved <= 1'b0;
      supported <= 1'b0;
      cur_key <= '0;
      new_key <= '0;
    end else if (state == resv_pkg::st_idle && cmd_valid) begin
      op <= cmd_is_resv ? cmd_op : resv_pkg::op_report;
      ns <= cmd_ns;
      host <= cmd_host;
      action <= cmd_action;
      ignore_key <= cmd_ignore_key;
      rights <= cmd_has_rights;
      reserved <= ns_reserved[cmd_ns];
      supported <= !cmd_is_resv || (ctrl_resv_support && ns_resv_support[cmd_ns]);
      cur_key <= cmd_current_key;
      new_key <= cmd_new_key;
    end
  end

  // --------------------------------------------------------------
  // Decision
  // --------------------------------------------------------------
  // Status and table update from the looked-up entry
  always_comb begin
    next_status = resv_pkg::st_success;
    wr_en = 1'b0;
    wr_valid = rd_valid;
    wr_key = rd_key;
    if (!supported) begin
      next_status = resv_pkg::st_invalid_opcode;
    end else if (reserved && !rights) begin
      next_status = resv_pkg::st_conflict;
    end else if (op == resv_pkg::op_register) begin
      if (action == resv_pkg::act_register) begin
        if (rd_valid && rd_key != new_key) begin
          next_status = resv_pkg::st_conflict;
        end else begin
          wr_en = 1'b1;
          wr_valid = 1'b1;
          wr_key = new_key;
        end
      end else if (action == resv_pkg::act_replace) begin
        if (!ignore_key && (!rd_valid || rd_key != cur_key)) begin
          next_status = resv_pkg::st_conflict;
        end else begin
          wr_en = 1'b1;
          wr_valid = 1'b1;
          wr_key = new_key;
        end
      end else if (action == resv_pkg::act_unregister) begin
        if (!rd_valid || (!ignore_key && rd_key != cur_key)) begin
          next_status = resv_pkg::st_conflict;
        end else begin
          wr_en = 1'b1;
          wr_valid = 1'b0;
          wr_key = '0;
        end
      end
    end
    if (state != resv_pkg::st_look) begin
      wr_en = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------
  // Idle, look up, complete
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= resv_pkg::st_idle;
    end else begin
      case (state)
        resv_pkg::st_idle: begin
          if (cmd_valid) begin
            state <= resv_pkg::st_look;
          end
        end
        resv_pkg::st_look: begin
          state <= resv_pkg::st_done;
        end
        default: begin
          state <= resv_pkg::st_idle;
        end
      endcase
    end
  end

  // Completion pulse and status
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpl_valid <= 1'b0;
      cpl_status <= resv_pkg::st_success;
      busy <= 1'b0;
    end else begin
      cpl_valid <= state == resv_pkg::st_look;
      busy <= (state == resv_pkg::st_idle && cmd_valid) || state == resv_pkg::st_look;
      if (state == resv_pkg::st_look) begin
        cpl_status <= next_status;
      end
    end
  end

  // --------------------------------------------------------------
  // Identify data and persist state
  // --------------------------------------------------------------
  // Controller support bit from the subsystem-wide setting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      optional_command_support_field <= 8'h00;
    end else begin
      optional_command_support_field <=
        8'(ctrl_resv_support) << resv_pkg::opt_cmd_resv_bit;
    end
  end

  // Per-namespace capability and persist flag
  genvar g;
  generate
    for (g = 0; g < num_ns; g++) begin : g_ns
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          reservation_capability_field[g*8 +: 8] <= 8'h00;
        end else begin
          reservation_capability_field[g*8 +: 8] <=
            ns_resv_support[g] ? resv_pkg::resv_cap_value : 8'h00;
        end
      end
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          power_loss_persist_state[g] <= resv_pkg::persist_reset;
        end else if (persist_set_en[g] && ns_resv_support[g]) begin
          power_loss_persist_state[g] <= persist_set_value;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_look;
    state == resv_pkg::st_look;
  endsequence

  chk_unsupported_opcode: assert property (@(posedge clk) disable iff (!arst_n)
    s_look and !supported |=> cpl_valid && cpl_status == resv_pkg::st_invalid_opcode)
    else $error("unsupported not invalid opcode");
  chk_support_bit: assert property (@(posedge clk) disable iff (!arst_n)
    optional_command_support_field[resv_pkg::opt_cmd_resv_bit] == $past(ctrl_resv_support))
    else $error("support bit wrong");
  chk_no_rights_conflict: assert property (@(posedge clk) disable iff (!arst_n)
    s_look and supported && reserved && !rights |=> cpl_status == resv_pkg::st_conflict)
    else $error("no conflict without rights");
  chk_rereg_diff_key: assert property (@(posedge clk) disable iff (!arst_n)
    s_look and supported && !reserved && op == resv_pkg::op_register &&
    action == resv_pkg::act_register && rd_valid && rd_key != new_key |-> !wr_en ##1
    cpl_status == resv_pkg::st_conflict) else $error("rereg key mismatch passed");
  chk_register_records: assert property (@(posedge clk) disable iff (!arst_n)
    s_look and supported && (!reserved || rights) && op == resv_pkg::op_register &&
    action == resv_pkg::act_register && !rd_valid |=> ##1 rd_valid && rd_key == new_key)
    else $error("register not recorded");
  chk_replace_mismatch: assert property (@(posedge clk) disable iff (!arst_n)
    s_look and supported && (!reserved || rights) && op == resv_pkg::op_register &&
    action == resv_pkg::act_replace && !ignore_key && rd_valid && rd_key != cur_key
    |-> !wr_en) else $error("replace mismatch wrote");
  chk_replace_ignore: assert property (@(posedge clk) disable iff (!arst_n)
    s_look and supported && (!reserved || rights) && op == resv_pkg::op_register &&
    action == resv_pkg::act_replace && ignore_key |-> wr_en && wr_key == new_key)
    else $error("ignore key replace failed");
  chk_unreg_unknown: assert property (@(posedge clk) disable iff (!arst_n)
    s_look and supported && (!reserved || rights) && op == resv_pkg::op_register &&
    action == resv_pkg::act_unregister && !rd_valid |=> cpl_status == resv_pkg::st_conflict)
    else $error("unregister of non-registrant");
  chk_cpl_timing: assert property (@(posedge clk) disable iff (!arst_n)
    state == resv_pkg::st_idle && cmd_valid |=> ##1 cpl_valid)
    else $error("completion late");
endmodule
`default_nettype wire
